// ===== rtl/node_led_defs.svh
// How it works
// - Green LED stays dark while the node is inactive.
// - Manager waits out the timeout; quiet bus starts setup phase one, traffic blocks it.
// - Managed node: timeout gives plain Ethernet, traffic gives setup phase one.
// - Plain Ethernet state flickers green at about 10 Hz.
// - Manager leaves plain Ethernet state only through an interface reset or a system stop.
// - Managed node in plain Ethernet goes to setup phase one on fieldbus traffic.
// - Setup phase one shows a single green flash each second.
// - Manager in setup phase one runs reduced cycle only, no cyclic traffic.
// - Managed node in phase one takes configuration, moves on at cycle start.
// - Setup phase two shows a double green flash each second.
// - Manager in phase two runs cyclic traffic, ignores inputs, configures nodes.
// - Managed node in phase two takes configuration; armed only on manager command.
// - Armed state shows a triple green flash each second.
// - Manager armed: cyclic and async traffic, received process data discarded.
// - Managed node armed: cyclic and async, transmits mapped data, no evaluation.
// - Managed node in setup or armed lights red when the manager has failed.
// - Running state holds green on, maps and evaluates process data.
// - Halted state blinks green at about 2.5 Hz.
// - A manager never enters the halted state.
// - Halted managed node moves no data; enters and leaves on manager command.
// - System stop shows four red phases of 150 or 600 ms, then 2 s pause.
// - Memory failure code is short, short, short, long.
// - Hardware failure code is long, short, short, long.
`ifndef NODE_LED_DEFS_SVH
`define NODE_LED_DEFS_SVH
`define NL_CLK_KHZ 20000
`define NL_TICK_MS 50
`define NL_TICK_CYCLES (`NL_TICK_MS * `NL_CLK_KHZ)
`define NL_TIMEOUT_TICKS 20
`define NL_SHORT_MS 150
`define NL_LONG_MS 600
`define NL_PAUSE_MS 2000
`define NL_SHORT_TICKS (`NL_SHORT_MS / `NL_TICK_MS)
`define NL_LONG_TICKS (`NL_LONG_MS / `NL_TICK_MS)
`define NL_PAUSE_TICKS (`NL_PAUSE_MS / `NL_TICK_MS)
`define NL_GAP_TICKS 3
`define NL_FLASH_PERIOD 20
`define NL_FLASH_ON 2
`define NL_FLASH_STEP 4
`define NL_BLINK_HALF 4
`define NL_CODE_MEMORY 4'h8
`define NL_CODE_HARDWARE 4'h9
`endif

// ===== rtl/node_led_pkg.sv
package node_led_pkg;
   typedef enum logic [2:0]
   {
      ST_INACTIVE = 3'h0,
      ST_PLAIN = 3'h1,
      ST_ONE = 3'h2,
      ST_TWO = 3'h3,
      ST_ARMED = 3'h4,
      ST_RUN = 3'h5,
      ST_HALT = 3'h6
   } node_state_e;
   typedef enum logic [2:0]
   {
      CMD_NONE = 3'h0,
      CMD_TO_ARMED = 3'h1,
      CMD_TO_RUN = 3'h2,
      CMD_ENTER_HALT = 3'h3,
      CMD_LEAVE_HALT = 3'h4
   } node_cmd_e;
   typedef enum logic [1:0]
   {
      FAIL_NONE = 2'h0,
      FAIL_MEMORY = 2'h1,
      FAIL_HARDWARE = 2'h2
   } stop_kind_e;
endpackage

// ===== rtl/fieldbus_node_state_led.sv
`timescale 1ns/100ps
`default_nettype none
`include "node_led_defs.svh"
module fieldbus_node_state_led
#(
   parameter int TICK_CYCLES = `NL_TICK_CYCLES,
   parameter int TIMEOUT_TICKS = `NL_TIMEOUT_TICKS
)
(
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   input wire logic ROLE_MANAGER_IN,
   input wire logic IF_RESET_IN,
   input wire logic FRAME_SEEN_IN,
   input wire logic CYCLE_START_IN,
   input wire logic MGR_STEP_IN,
   input wire logic CMD_VALID_IN,
   input wire node_led_pkg::node_cmd_e CMD_CODE_IN,
   input wire logic MANAGER_FAIL_IN,
   input wire node_led_pkg::stop_kind_e SYS_STOP_IN,
   output logic GREEN_LED_OUT,
   output logic RED_LED_OUT,
   output node_led_pkg::node_state_e STATE_OUT,
   output logic ETH_MODE_OUT,
   output logic REDUCED_CYCLE_OUT,
   output logic CYCLIC_EN_OUT,
   output logic ASYNC_EN_OUT,
   output logic TX_MAPPED_OUT,
   output logic RX_EVAL_OUT,
   output logic CONFIG_ACCEPT_OUT,
   output logic CONFIG_NODES_OUT
);
   import node_led_pkg::*;
   if (TICK_CYCLES < 1 || TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 65535)
   begin : g_bad_params
      $error("TICK_CYCLES must be at least one and TIMEOUT_TICKS within 1 to 65535");
   end

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   // One tick paces every LED pattern, so a single divider serves all timings.
   logic [31:0] tick_cnt_r;
   logic tick_r;
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         tick_cnt_r <= 32'h0;
         tick_r <= 1'b0;
      end
      else if (tick_cnt_r == 32'(TICK_CYCLES - 1))
      begin
         tick_cnt_r <= 32'h0;
         tick_r <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Node state
   // ----------------------------------------
   node_state_e state_r;
   logic mgr_r;
   logic mgr_block_r;
   logic [15:0] to_cnt_r;
   logic to_done;
   logic halted_state;
   assign to_done = (to_cnt_r == 16'(TIMEOUT_TICKS));
   assign halted_state = (SYS_STOP_IN != FAIL_NONE);
   // The role is only taken while inactive, so a stray change cannot skip states.
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         mgr_r <= 1'b0;
      else if (state_r == ST_INACTIVE)
         mgr_r <= ROLE_MANAGER_IN;
   end
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         to_cnt_r <= 16'h0;
      else if (IF_RESET_IN || state_r != ST_INACTIVE || mgr_block_r)
         to_cnt_r <= 16'h0;
      else if (tick_r && !to_done)
         to_cnt_r <= to_cnt_r + 16'h1;
   end
   // Traffic seen in the same cycle as an interface reset still blocks the start.
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         mgr_block_r <= 1'b0;
      else if (state_r == ST_INACTIVE && mgr_r && FRAME_SEEN_IN)
         mgr_block_r <= 1'b1;
      else if (IF_RESET_IN)
         mgr_block_r <= 1'b0;
   end
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         state_r <= ST_INACTIVE;
      else if (IF_RESET_IN || halted_state)
         state_r <= ST_INACTIVE;
      else
      begin
         case (state_r)
            ST_INACTIVE:
            begin
               if (mgr_r)
               begin
                  if (!mgr_block_r && !FRAME_SEEN_IN && to_done)
                     state_r <= ST_ONE;
               end
               else if (FRAME_SEEN_IN)
                  state_r <= ST_ONE;
               else if (to_done)
                  state_r <= ST_PLAIN;
            end
            ST_PLAIN:
               if (!mgr_r && FRAME_SEEN_IN)
                  state_r <= ST_ONE;
            ST_ONE:
               if (mgr_r ? MGR_STEP_IN : CYCLE_START_IN)
                  state_r <= ST_TWO;
            ST_TWO:
            begin
               if (mgr_r && MGR_STEP_IN)
                  state_r <= ST_ARMED;
               else if (!mgr_r && CMD_VALID_IN && CMD_CODE_IN == CMD_TO_ARMED)
                  state_r <= ST_ARMED;
               else if (!mgr_r && CMD_VALID_IN && CMD_CODE_IN == CMD_ENTER_HALT)
                  state_r <= ST_HALT;
            end
            ST_ARMED:
            begin
               if (mgr_r && MGR_STEP_IN)
                  state_r <= ST_RUN;
               else if (!mgr_r && CMD_VALID_IN && CMD_CODE_IN == CMD_TO_RUN)
                  state_r <= ST_RUN;
               else if (!mgr_r && CMD_VALID_IN && CMD_CODE_IN == CMD_ENTER_HALT)
                  state_r <= ST_HALT;
            end
            ST_RUN:
               if (!mgr_r && CMD_VALID_IN && CMD_CODE_IN == CMD_ENTER_HALT)
                  state_r <= ST_HALT;
            ST_HALT:
               if (CMD_VALID_IN && CMD_CODE_IN == CMD_LEAVE_HALT)
                  state_r <= ST_TWO;
            default:
               state_r <= ST_INACTIVE;
         endcase
      end
   end
   // ----------------------------------------
   // Communication enables
   // ----------------------------------------
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         STATE_OUT <= ST_INACTIVE;
         ETH_MODE_OUT <= 1'b0;
         REDUCED_CYCLE_OUT <= 1'b0;
         CYCLIC_EN_OUT <= 1'b0;
         ASYNC_EN_OUT <= 1'b0;
         TX_MAPPED_OUT <= 1'b0;
         RX_EVAL_OUT <= 1'b0;
         CONFIG_ACCEPT_OUT <= 1'b0;
         CONFIG_NODES_OUT <= 1'b0;
      end
      else
      begin
         STATE_OUT <= state_r;
         ETH_MODE_OUT <= (state_r == ST_PLAIN);
         REDUCED_CYCLE_OUT <= mgr_r && state_r == ST_ONE;
         CYCLIC_EN_OUT <= (mgr_r && state_r == ST_TWO) || state_r == ST_ARMED
                          || state_r == ST_RUN;
         ASYNC_EN_OUT <= state_r == ST_ARMED || state_r == ST_RUN;
         TX_MAPPED_OUT <= (!mgr_r && state_r == ST_ARMED) || state_r == ST_RUN;
         RX_EVAL_OUT <= (state_r == ST_RUN);
         CONFIG_ACCEPT_OUT <= !mgr_r && (state_r == ST_ONE || state_r == ST_TWO);
         CONFIG_NODES_OUT <= mgr_r && state_r == ST_TWO;
      end
   end
   // ----------------------------------------
   // Green patterns
   // ----------------------------------------
   logic [4:0] flash_ph_r;
   logic [2:0] blink_ph_r;
   logic flicker_r;
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         flash_ph_r <= 5'h0;
         blink_ph_r <= 3'h0;
         flicker_r <= 1'b0;
      end
      else if (tick_r)
      begin
         flash_ph_r <= (flash_ph_r == 5'(`NL_FLASH_PERIOD - 1)) ? 5'h0 : flash_ph_r + 5'h1;
         blink_ph_r <= (blink_ph_r == 3'(2 * `NL_BLINK_HALF - 1)) ? 3'h0 : blink_ph_r + 3'h1;
         flicker_r <= !flicker_r;
      end
   end
   // A flash is lit in the first ticks of each step; the number of steps is the count.
   function automatic logic flash_on(input logic [4:0] ph, input logic [1:0] n);
      logic [4:0] step;
      step = ph / 5'(`NL_FLASH_STEP);
      flash_on = (step < 5'(n)) && ((ph % 5'(`NL_FLASH_STEP)) < 5'(`NL_FLASH_ON));
   endfunction
   logic green_nxt;
   always_comb
   begin
      case (state_r)
         ST_INACTIVE: green_nxt = 1'b0;
         ST_PLAIN: green_nxt = flicker_r;
         ST_ONE: green_nxt = flash_on(flash_ph_r, 2'h1);
         ST_TWO: green_nxt = flash_on(flash_ph_r, 2'h2);
         ST_ARMED: green_nxt = flash_on(flash_ph_r, 2'h3);
         ST_RUN: green_nxt = 1'b1;
         ST_HALT: green_nxt = (blink_ph_r < 3'(`NL_BLINK_HALF));
         default: green_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         GREEN_LED_OUT <= 1'b0;
      else
         GREEN_LED_OUT <= green_nxt;
   end
   // ----------------------------------------
   // Red error sequencer
   // ----------------------------------------
   // The code is fixed at the first stop so a flickering cause cannot garble it.
   logic [3:0] code_r;
   logic stop_r;
   logic [1:0] err_idx_r;
   logic err_on_r;
   logic err_pause_r;
   logic [7:0] err_cnt_r;
   logic [7:0] err_len;
   assign err_len = err_pause_r ? 8'(`NL_PAUSE_TICKS)
                  : !err_on_r ? 8'(`NL_GAP_TICKS)
                  : code_r[err_idx_r] ? 8'(`NL_LONG_TICKS) : 8'(`NL_SHORT_TICKS);
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         stop_r <= 1'b0;
         code_r <= 4'h0;
      end
      else if (halted_state && !stop_r)
      begin
         stop_r <= 1'b1;
         code_r <= (SYS_STOP_IN == FAIL_MEMORY) ? `NL_CODE_MEMORY : `NL_CODE_HARDWARE;
      end
   end
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
      begin
         err_idx_r <= 2'h0;
         err_on_r <= 1'b0;
         err_pause_r <= 1'b0;
         err_cnt_r <= 8'h0;
      end
      else if (!stop_r)
      begin
         err_idx_r <= 2'h0;
         err_on_r <= halted_state;
         err_pause_r <= 1'b0;
         err_cnt_r <= 8'h0;
      end
      else if (tick_r)
      begin
         if (err_cnt_r != err_len - 8'h1)
            err_cnt_r <= err_cnt_r + 8'h1;
         else
         begin
            err_cnt_r <= 8'h0;
            if (err_pause_r)
            begin
               err_pause_r <= 1'b0;
               err_on_r <= 1'b1;
            end
            else if (err_on_r && err_idx_r == 2'h3)
            begin
               err_on_r <= 1'b0;
               err_pause_r <= 1'b1;
               err_idx_r <= 2'h0;
            end
            else if (err_on_r)
               err_on_r <= 1'b0;
            else
            begin
               err_on_r <= 1'b1;
               err_idx_r <= err_idx_r + 2'h1;
            end
         end
      end
   end
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         RED_LED_OUT <= 1'b0;
      else if (stop_r)
         RED_LED_OUT <= err_on_r;
      else
         RED_LED_OUT <= MANAGER_FAIL_IN && !mgr_r
                        && (state_r == ST_ONE || state_r == ST_TWO || state_r == ST_ARMED);
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [7:0] onlen_r;
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
   begin
      if (SYS_RST_IN)
         onlen_r <= 8'h0;
      else if (!err_on_r)
         onlen_r <= 8'h0;
      else if (tick_r)
         onlen_r <= onlen_r + 8'h1;
   end
   sequence s_quiet_timeout;
      state_r == ST_INACTIVE && !IF_RESET_IN && !halted_state && !FRAME_SEEN_IN && to_done;
   endsequence
   sequence s_cycle_start;
      state_r == ST_ONE && !mgr_r && CYCLE_START_IN && !IF_RESET_IN && !halted_state;
   endsequence
   a_green_dark_inactive: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state_r == ST_INACTIVE |=> !GREEN_LED_OUT)
      else $error("green lit while inactive");
   a_mgr_timeout_start: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      s_quiet_timeout and mgr_r && !mgr_block_r |=> state_r == ST_ONE)
      else $error("manager did not start after quiet timeout");
   a_node_timeout_plain: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      s_quiet_timeout and !mgr_r |=> state_r == ST_PLAIN)
      else $error("managed node did not fall back to plain ethernet");
   a_mgr_plain_sticks: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state_r == ST_PLAIN && mgr_r && !IF_RESET_IN && !halted_state |=> state_r == ST_PLAIN)
      else $error("manager left plain ethernet without reset");
   a_node_cycle_start: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      s_cycle_start |=> state_r == ST_TWO ##1 STATE_OUT == ST_TWO)
      else $error("cycle start did not reach setup phase two");
   a_mgr_never_halt: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state_r == ST_HALT |-> !mgr_r)
      else $error("manager in halted state");
   a_halt_no_data: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state_r == ST_HALT [*2] |-> !TX_MAPPED_OUT && !RX_EVAL_OUT && !CYCLIC_EN_OUT)
      else $error("halted node moves data");
   a_red_mgr_fail: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      !stop_r && MANAGER_FAIL_IN && !mgr_r && state_r inside {ST_ONE, ST_TWO, ST_ARMED}
      |=> RED_LED_OUT)
      else $error("red not lit on manager failure");
   a_err_phase_len: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      stop_r && $fell(err_on_r) |-> onlen_r == 8'(`NL_SHORT_TICKS) || onlen_r == 8'(`NL_LONG_TICKS))
      else $error("red on-phase length wrong");
   a_running_green: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state_r == ST_RUN |=> GREEN_LED_OUT && RX_EVAL_OUT)
      else $error("running state not shown steadily");
endmodule
`default_nettype wire

// ===== rtl/unused_placeholder_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== dv/mgr_model.sv
`timescale 1ns/100ps
`default_nettype none
module mgr_model
(
   input wire logic clk_in,
   output logic frame_out,
   output logic cycle_start_out,
   output logic cmd_valid_out,
   output node_led_pkg::node_cmd_e cmd_code_out,
   output logic mgr_fail_out
);
   import node_led_pkg::*;
   // ----------------------------------------
   // Far side: managing node and bus traffic
   // ----------------------------------------
   initial
   begin
      frame_out = 1'b0;
      cycle_start_out = 1'b0;
      cmd_valid_out = 1'b0;
      cmd_code_out = CMD_NONE;
      mgr_fail_out = 1'b0;
   end
   task automatic send_frame();
      @(posedge clk_in);
      #5 frame_out = 1'b1;
      @(posedge clk_in);
      #5 frame_out = 1'b0;
   endtask
   task automatic send_soc();
      @(posedge clk_in);
      #5 cycle_start_out = 1'b1;
      @(posedge clk_in);
      #5 cycle_start_out = 1'b0;
   endtask
   // The code lines are not held after the strobe, so the inverse is shown to catch late sampling.
   task automatic send_cmd(input node_cmd_e code);
      @(posedge clk_in);
      #5 cmd_code_out = code;
      cmd_valid_out = 1'b1;
      @(posedge clk_in);
      #5 cmd_valid_out = 1'b0;
      cmd_code_out = node_cmd_e'(~code);
   endtask
   task automatic set_fail(input logic f);
      @(posedge clk_in);
      #5 mgr_fail_out = f;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import node_led_pkg::*;
   logic clk, rst, role_mgr, if_rst, step, frame, soc, cmd_valid, mgr_fail;
   logic green, red, eth, reduced, cyclic, async_en, tx_map, rx_eval, cfg_acc, cfg_nodes;
   node_cmd_e cmd_code;
   stop_kind_e stop;
   node_state_e state;
   int n_mismatch = 0;
   int check_count = 0;
   // ----------------------------------------
   // Clock, design and far side
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // A tick of four clocks keeps a full flash period at 80 clocks.
   fieldbus_node_state_led #(.TICK_CYCLES(4), .TIMEOUT_TICKS(3)) i_dut
   (
      .CLOCK_IN(clk), .SYS_RST_IN(rst), .ROLE_MANAGER_IN(role_mgr), .IF_RESET_IN(if_rst),
      .FRAME_SEEN_IN(frame), .CYCLE_START_IN(soc), .MGR_STEP_IN(step), .CMD_VALID_IN(cmd_valid),
      .CMD_CODE_IN(cmd_code), .MANAGER_FAIL_IN(mgr_fail), .SYS_STOP_IN(stop),
      .GREEN_LED_OUT(green), .RED_LED_OUT(red), .STATE_OUT(state), .ETH_MODE_OUT(eth),
      .REDUCED_CYCLE_OUT(reduced), .CYCLIC_EN_OUT(cyclic), .ASYNC_EN_OUT(async_en),
      .TX_MAPPED_OUT(tx_map), .RX_EVAL_OUT(rx_eval), .CONFIG_ACCEPT_OUT(cfg_acc),
      .CONFIG_NODES_OUT(cfg_nodes)
   );
   mgr_model i_mgr
   (
      .clk_in(clk), .frame_out(frame), .cycle_start_out(soc), .cmd_valid_out(cmd_valid),
      .cmd_code_out(cmd_code), .mgr_fail_out(mgr_fail)
   );
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic mgr);
      @(posedge clk);
      #5 rst = 1'b1;
      role_mgr = mgr;
      stop = FAIL_NONE;
      repeat (5) @(posedge clk);
      #5 rst = 1'b0;
   endtask
   task automatic wait_state(input node_state_e s, input int lim);
      int n;
      n = 0;
      while (state !== s && n < lim)
      begin
         cyc(1);
         n++;
      end
      chk("state", {29'h0, s}, {29'h0, state});
   endtask
   // Counting rises over exactly one period gives the flash count whatever the phase.
   task automatic rises(input int win, input int exp, input string what);
      int c;
      logic prev;
      c = 0;
      prev = green;
      repeat (win)
      begin
         cyc(1);
         if (green === 1'b1 && prev === 1'b0)
            c++;
         prev = green;
      end
      chk(what, exp, c);
   endtask
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (red === lvl && n < 400)
      begin
         cyc(1);
         n++;
      end
   endtask
   task automatic pulse(ref logic sig);
      @(posedge clk);
      #5 sig = 1'b1;
      @(posedge clk);
      #5 sig = 1'b0;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_managed_timeout();
      do_reset(1'b0);
      cyc(2);
      chk("green inactive", 0, green);
      wait_state(ST_PLAIN, 100);
      chk("eth mode", 1, eth);
      rises(64, 8, "flicker");
      i_mgr.send_frame();
      wait_state(ST_ONE, 4);
      $display("done managed timeout");
   endtask
   task automatic t_managed_walk();
      do_reset(1'b0);
      i_mgr.send_frame();
      wait_state(ST_ONE, 4);
      chk("cfg accept", 1, cfg_acc);
      rises(80, 1, "single flash");
      i_mgr.send_soc();
      wait_state(ST_TWO, 4);
      rises(80, 2, "double flash");
      i_mgr.send_cmd(CMD_TO_RUN);
      cyc(3);
      chk("ignored cmd", {29'h0, ST_TWO}, {29'h0, state});
      i_mgr.send_cmd(CMD_TO_ARMED);
      wait_state(ST_ARMED, 4);
      rises(80, 3, "triple flash");
      chk("tx mapped", 1, tx_map);
      chk("rx eval armed", 0, rx_eval);
      i_mgr.set_fail(1'b1);
      cyc(3);
      chk("red mgr fail", 1, red);
      i_mgr.send_cmd(CMD_TO_RUN);
      wait_state(ST_RUN, 4);
      rises(80, 0, "steady rises");
      chk("green steady", 1, green);
      chk("rx eval run", 1, rx_eval);
      chk("red in run", 0, red);
      i_mgr.set_fail(1'b0);
      i_mgr.send_cmd(CMD_ENTER_HALT);
      wait_state(ST_HALT, 4);
      rises(64, 2, "blink");
      chk("halt tx", 0, tx_map);
      chk("halt rx", 0, rx_eval);
      i_mgr.send_cmd(CMD_LEAVE_HALT);
      wait_state(ST_TWO, 4);
      $display("done managed walk");
   endtask
   task automatic t_manager();
      do_reset(1'b1);
      wait_state(ST_ONE, 100);
      chk("reduced", 1, reduced);
      chk("cyclic one", 0, cyclic);
      pulse(step);
      wait_state(ST_TWO, 4);
      chk("cyclic two", 1, cyclic);
      chk("cfg nodes", 1, cfg_nodes);
      chk("rx eval two", 0, rx_eval);
      i_mgr.send_cmd(CMD_ENTER_HALT);
      cyc(3);
      chk("no halt", {29'h0, ST_TWO}, {29'h0, state});
      pulse(step);
      wait_state(ST_ARMED, 4);
      chk("async armed", 1, async_en);
      chk("rx discard", 0, rx_eval);
      pulse(step);
      wait_state(ST_RUN, 4);
      $display("done manager");
   endtask
   task automatic t_manager_blocked();
      do_reset(1'b1);
      i_mgr.send_frame();
      cyc(100);
      chk("blocked", {29'h0, ST_INACTIVE}, {29'h0, state});
      pulse(if_rst);
      wait_state(ST_ONE, 100);
      $display("done manager blocked");
   endtask
   task automatic t_stop(input stop_kind_e k, input logic [3:0] longs);
      int n, i;
      do_reset(1'b0);
      @(posedge clk);
      #5 stop = k;
      run_len(1'b0, n);
      for (i = 0; i < 10; i++)
      begin
         run_len(1'b1, n);
         run_len(1'b0, n);
         if (n >= 100)
            break;
      end
      for (i = 0; i < 4; i++)
      begin
         run_len(1'b1, n);
         chk("red phase", longs[i] ? 48 : 12, n);
         if (i < 3)
         begin
            run_len(1'b0, n);
            chk("red gap", 12, n);
         end
      end
      run_len(1'b0, n);
      chk("red pause", 160, n);
      chk("green stop", 0, green);
      $display("done stop");
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      rst = 1'b1;
      role_mgr = 1'b0;
      if_rst = 1'b0;
      step = 1'b0;
      stop = FAIL_NONE;
      t_managed_timeout();
      t_managed_walk();
      t_manager();
      t_manager_blocked();
      t_stop(FAIL_MEMORY, 4'b1000);
      t_stop(FAIL_HARDWARE, 4'b1001);
      finish_test();
   end
   initial
   begin
      #(50 * 20000);
      n_mismatch++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test();
   end
endmodule
`default_nettype wire
